/* design/usc_pkg.sv */
// constants and types for the dual serial port control block
package usc_pkg;
  // ==========================================
  // register port and map
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 8;
  localparam int         NPORT        = 2;
  localparam int         BANK_BIT     = 7;
  localparam logic [6:0] OFF_IRQ_STAT = 7'h10;
  localparam logic [6:0] OFF_IRQ_MASK = 7'h11;
  localparam logic [6:0] OFF_RX_CTL   = 7'h13;
  localparam logic [6:0] OFF_RX_BUF   = 7'h14;
  localparam logic [6:0] OFF_TX_CTL   = 7'h15;
  localparam logic [6:0] OFF_TX_BUF   = 7'h16;
  localparam logic [6:0] OFF_BAUD     = 7'h17;
  // ==========================================
  // field positions
  localparam int CLOCK_SOURCE_SELECT_BIT   = 7;
  localparam int TX9_BIT    = 6;
  localparam int TRANSMIT_ENABLE_BIT   = 5;
  localparam int SYNC_BIT   = 4;
  localparam int SHIFT_EMPTY_FLAG_BIT   = 1;
  localparam int TX_NINTH_DATA_BIT_BIT   = 0;
  localparam int PORT_ENABLE_BIT   = 7;
  localparam int SINGLE_RECEIVE_ENABLE_BIT   = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT   = 4;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  // ==========================================
  // write masks and reset values
  localparam logic [7:0] TX_CTL_WMASK = 8'hF1;
  localparam logic [7:0] RX_CTL_WMASK = 8'hF0;
  localparam logic [7:0] CTL_RST      = 8'h00;
  localparam logic [1:0] IRQ_RST      = 2'h0;
  // ==========================================
  // timing and frame lengths
  localparam int         ASYNC_SHIFT = 6;   // 64 clocks per divisor step
  localparam int         SYNC_SHIFT  = 1;   // half of 4 clocks per step
  localparam logic [3:0] ALEN8       = 4'hA;
  localparam logic [3:0] ALEN9       = 4'hB;
  localparam logic [3:0] SLEN8       = 4'h8;
  localparam logic [3:0] SLEN9       = 4'h9;
  // ==========================================
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ASYNC = 3'b010,
    ST_SYNC  = 3'b100
  } usc_state_type;
  // last count of the baud divider
  function automatic logic [13:0] div_limit(input logic sync, input logic [7:0] x);
    logic [13:0] n;
    n = {6'h00, x} + 14'h0001;
    return sync ? 14'((n << SYNC_SHIFT) - 14'h0001) : 14'((n << ASYNC_SHIFT) - 14'h0001);
  endfunction : div_limit
endpackage : usc_pkg

/* design/usc_top.sv */
// dual serial port: per-port mode, transmit control, pins and interrupts
`timescale 1ns/1ps
`default_nettype none

module usc_port #(
  parameter logic PORT_ID = 1'b0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  // interrupt
  output logic            irq,
  // pins
  input  wire logic       receiveDataPinIn,
  output logic            receiveDataPinOut,
  output logic            receiveDataPinOe,
  input  wire logic       transmitClockPinIn,
  output logic            transmitClockPinOut,
  output logic            transmitClockPinOe
);
  // ==========================================
  // state
  logic [7:0]             txCtl_reg, txCtl_next, rxCtl_reg, rxCtl_next;
  logic [7:0]             baud_reg, baud_next, txBuf_reg, txBuf_next;
  logic [7:0]             rxBuf_reg, rxBuf_next, rdData_reg, rdData_next;
  logic                   bufFull_reg, bufFull_next, txMode_reg, txMode_next;
  logic [1:0]             irqStat_reg, irqStat_next, irqMask_reg, irqMask_next;
  logic [10:0]            shift_reg, shift_next;
  logic [3:0]             bitCnt_reg, bitCnt_next, frameLen_reg, frameLen_next;
  logic [13:0]            divCnt_reg, divCnt_next;
  logic                   ckLine_reg, ckLine_next, dtLine_reg, dtLine_next;
  logic                   ckInPrev_reg, ckInPrev_next;
  usc_pkg::usc_state_type state_reg, state_next;
  logic                   sel, port_enable, single_receive_enable, continuous_receive_enable, clock_source_select, sync, transmit_enable, tx9, shift_empty_flag;
  logic                   tick, rise, fall, txLoad, rxDone, lastBit;
  logic [6:0]             off;
  logic [1:0]             clr;

  // ==========================================
  // decoded mode and control bits
  assign sel  = (addr[usc_pkg::BANK_BIT] == PORT_ID);
  assign off  = addr[6:0];
  assign port_enable = rxCtl_reg[usc_pkg::PORT_ENABLE_BIT];
  assign single_receive_enable = rxCtl_reg[usc_pkg::SINGLE_RECEIVE_ENABLE_BIT];
  assign continuous_receive_enable = rxCtl_reg[usc_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
  assign clock_source_select = txCtl_reg[usc_pkg::CLOCK_SOURCE_SELECT_BIT];
  assign sync = txCtl_reg[usc_pkg::SYNC_BIT];
  assign transmit_enable = txCtl_reg[usc_pkg::TRANSMIT_ENABLE_BIT];
  assign tx9  = txCtl_reg[usc_pkg::TX9_BIT];
  assign shift_empty_flag = !(txMode_reg && state_reg != usc_pkg::ST_IDLE);
  assign tick = (divCnt_reg == usc_pkg::div_limit(sync, baud_reg));
  // clock edges from own clock or partner
  assign rise = clock_source_select ? (tick && !ckLine_reg) : (transmitClockPinIn && !ckInPrev_reg);
  assign fall = clock_source_select ? (tick && ckLine_reg) : (!transmitClockPinIn && ckInPrev_reg);
  assign lastBit = (bitCnt_reg == frameLen_reg - 4'h1);
  assign clr = (wrEn && sel && off == usc_pkg::OFF_IRQ_STAT) ? wrData[1:0] : 2'h0;

  // ==========================================
  // registers, reads and serial engine
  always_comb begin
    txCtl_next    = txCtl_reg;
    rxCtl_next    = rxCtl_reg;
    baud_next     = baud_reg;
    txBuf_next    = txBuf_reg;
    rxBuf_next    = rxBuf_reg;
    bufFull_next  = bufFull_reg;
    txMode_next   = txMode_reg;
    irqMask_next  = irqMask_reg;
    shift_next    = shift_reg;
    bitCnt_next   = bitCnt_reg;
    frameLen_next = frameLen_reg;
    ckLine_next   = ckLine_reg;
    dtLine_next   = dtLine_reg;
    state_next    = state_reg;
    ckInPrev_next = transmitClockPinIn;
    rdData_next   = 8'h00;
    txLoad        = 1'b0;
    rxDone        = 1'b0;
    // software writes
    if (wrEn && sel) begin
      case (off)
        usc_pkg::OFF_TX_CTL:   txCtl_next = wrData & usc_pkg::TX_CTL_WMASK;
        usc_pkg::OFF_RX_CTL:   rxCtl_next = wrData & usc_pkg::RX_CTL_WMASK;
        usc_pkg::OFF_BAUD:     baud_next = wrData;
        usc_pkg::OFF_IRQ_MASK: irqMask_next = wrData[1:0];
        usc_pkg::OFF_TX_BUF: begin
          txBuf_next   = wrData;
          bufFull_next = 1'b1;
        end
        default: ;
      endcase
    end
    // read data, zero for unmapped offsets
    if (rdEn && sel) begin
      case (off)
        usc_pkg::OFF_TX_CTL: begin
          rdData_next = txCtl_reg;
          rdData_next[usc_pkg::SHIFT_EMPTY_FLAG_BIT] = shift_empty_flag;
        end
        usc_pkg::OFF_RX_CTL:   rdData_next = rxCtl_reg;
        usc_pkg::OFF_BAUD:     rdData_next = baud_reg;
        usc_pkg::OFF_TX_BUF:   rdData_next = txBuf_reg;
        usc_pkg::OFF_RX_BUF:   rdData_next = rxBuf_reg;
        usc_pkg::OFF_IRQ_STAT: rdData_next = {6'h00, irqStat_reg};
        usc_pkg::OFF_IRQ_MASK: rdData_next = {6'h00, irqMask_reg};
        default:               rdData_next = 8'h00;
      endcase
    end
    // engine
    case (state_reg)
      usc_pkg::ST_IDLE: begin
        ckLine_next = !sync;  // mark level async, clock low sync
        // sync receive start, single only as master
        if (port_enable && sync && (continuous_receive_enable || (single_receive_enable && clock_source_select))) begin
          state_next    = usc_pkg::ST_SYNC;
          txMode_next   = 1'b0;
          bitCnt_next   = 4'h0;
          frameLen_next = usc_pkg::SLEN8;
        // transmit only when enabled and no receive
        end else if (port_enable && transmit_enable && bufFull_reg && !(sync && (single_receive_enable || continuous_receive_enable))) begin
          txLoad       = 1'b1;
          bufFull_next = 1'b0;
          txMode_next  = 1'b1;
          bitCnt_next  = 4'h0;
          // ninth bit taken from control register
          if (sync) begin
            shift_next    = {2'b11, txCtl_reg[usc_pkg::TX_NINTH_DATA_BIT_BIT], txBuf_reg};
            frameLen_next = tx9 ? usc_pkg::SLEN9 : usc_pkg::SLEN8;
            dtLine_next   = txBuf_reg[0];
            state_next    = usc_pkg::ST_SYNC;
          end else begin
            shift_next    = {1'b1, tx9 ? txCtl_reg[usc_pkg::TX_NINTH_DATA_BIT_BIT] : 1'b1, txBuf_reg, 1'b0};
            frameLen_next = tx9 ? usc_pkg::ALEN9 : usc_pkg::ALEN8;
            ckLine_next   = 1'b0;
            state_next    = usc_pkg::ST_ASYNC;
          end
        end
      end
      usc_pkg::ST_ASYNC: begin
        if (tick) begin
          shift_next  = {1'b1, shift_reg[10:1]};
          bitCnt_next = bitCnt_reg + 4'h1;
          if (lastBit) begin
            state_next = usc_pkg::ST_IDLE;
          end
        end
        ckLine_next = shift_next[0];
      end
      usc_pkg::ST_SYNC: begin
        if (clock_source_select && tick) begin
          ckLine_next = !ckLine_reg;
        end
        if (rise && !txMode_reg) begin
          shift_next = {shift_reg[10:8], receiveDataPinIn, shift_reg[7:1]};
        end
        if (fall) begin
          bitCnt_next = bitCnt_reg + 4'h1;
          if (txMode_reg) begin
            shift_next  = {1'b0, shift_reg[10:1]};
            dtLine_next = shift_reg[1];
          end
          if (lastBit) begin
            state_next = usc_pkg::ST_IDLE;
            if (!txMode_reg) begin
              rxDone     = 1'b1;
              rxBuf_next = shift_reg[7:0];
              if (clock_source_select && !continuous_receive_enable) begin
                rxCtl_next[usc_pkg::SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
              end
            end
          end
        end
      end
      default: state_next = usc_pkg::ST_IDLE;
    endcase
    // port disable stops the engine
    if (!port_enable) begin
      state_next = usc_pkg::ST_IDLE;
    end
    divCnt_next = (state_reg == usc_pkg::ST_IDLE || tick) ? 14'h0000 : divCnt_reg + 14'h0001;
    // sticky flags, set wins over write-one clear
    irqStat_next = (irqStat_reg & ~clr) | {rxDone, txLoad};
  end

  // register update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txCtl_reg    <= usc_pkg::CTL_RST;
      rxCtl_reg    <= usc_pkg::CTL_RST;
      baud_reg     <= 8'h00;
      txBuf_reg    <= 8'h00;
      rxBuf_reg    <= 8'h00;
      rdData_reg   <= 8'h00;
      bufFull_reg  <= 1'b0;
      txMode_reg   <= 1'b0;
      irqStat_reg  <= usc_pkg::IRQ_RST;
      irqMask_reg  <= usc_pkg::IRQ_RST;
      shift_reg    <= 11'h7FF;
      bitCnt_reg   <= 4'h0;
      frameLen_reg <= 4'h0;
      divCnt_reg   <= 14'h0000;
      ckLine_reg   <= 1'b1;
      dtLine_reg   <= 1'b0;
      ckInPrev_reg <= 1'b0;
      state_reg    <= usc_pkg::ST_IDLE;
    end else begin
      txCtl_reg    <= txCtl_next;
      rxCtl_reg    <= rxCtl_next;
      baud_reg     <= baud_next;
      txBuf_reg    <= txBuf_next;
      rxBuf_reg    <= rxBuf_next;
      rdData_reg   <= rdData_next;
      bufFull_reg  <= bufFull_next;
      txMode_reg   <= txMode_next;
      irqStat_reg  <= irqStat_next;
      irqMask_reg  <= irqMask_next;
      shift_reg    <= shift_next;
      bitCnt_reg   <= bitCnt_next;
      frameLen_reg <= frameLen_next;
      divCnt_reg   <= divCnt_next;
      ckLine_reg   <= ckLine_next;
      dtLine_reg   <= dtLine_next;
      ckInPrev_reg <= ckInPrev_next;
      state_reg    <= state_next;
    end
  end

  // ==========================================
  // outputs; pin ownership and direction
  assign rdData              = rdData_reg;
  assign irq                 = |(irqStat_reg & irqMask_reg);
  assign transmitClockPinOut = ckLine_reg;
  assign transmitClockPinOe  = port_enable && (!sync || clock_source_select);
  assign receiveDataPinOut   = dtLine_reg;
  assign receiveDataPinOe    = port_enable && sync && transmit_enable && !(single_receive_enable || continuous_receive_enable);

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_pins_released: assert property (!port_enable |-> !transmitClockPinOe && !receiveDataPinOe)
    else $error("pins driven while port disabled");
  chk_rx_over_tx: assert property (sync && (single_receive_enable || continuous_receive_enable) |-> !receiveDataPinOe && !txLoad)
    else $error("transmit active during sync receive");
  chk_async_clk_ignored: assert property (port_enable && !sync |-> transmitClockPinOe)
    else $error("async line not driven");
  chk_slave_clk_input: assert property (port_enable && sync && !clock_source_select |-> !transmitClockPinOe)
    else $error("slave drives clock pin");
  chk_single_rx_clear: assert property (rxDone && clock_source_select && !continuous_receive_enable |=> !single_receive_enable)
    else $error("single receive not cleared");
  chk_cont_rx_holds: assert property (rxDone && continuous_receive_enable && single_receive_enable &&
    !(wrEn && sel && off == usc_pkg::OFF_RX_CTL) |=> single_receive_enable && continuous_receive_enable)
    else $error("continuous receive dropped enables");
  chk_nine_bit_len: assert property (txLoad && tx9 && !sync |=>
    frameLen_reg == usc_pkg::ALEN9) else $error("nine bit frame length wrong");
  chk_shift_busy: assert property (txLoad |=> !shift_empty_flag && state_reg != usc_pkg::ST_IDLE)
    else $error("shift empty flag not cleared on load");
  chk_baud_bound: assert property (state_reg == usc_pkg::ST_ASYNC |->
    divCnt_reg <= usc_pkg::div_limit(1'b0, baud_reg)) else $error("async divider beyond limit");
  chk_sync_only_rx: assert property (rxDone |-> sync &&
    $past(state_reg) == usc_pkg::ST_SYNC) else $error("sync receive outside sync mode");

  cov_async_tx: cover property (txLoad && !sync ##[1:1000] state_reg == usc_pkg::ST_IDLE);
  cov_master_rx: cover property (rxDone && clock_source_select && single_receive_enable);
  cov_slave_tx: cover property (txLoad && sync && !clock_source_select);
  cov_irq: cover property ($rose(irq));
endmodule : usc_port

// top: two identical ports on one register port
module usc_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // register port
  input  wire logic [7:0]                addr,
  input  wire logic [7:0]                wrData,
  input  wire logic                      wrEn,
  input  wire logic                      rdEn,
  output logic      [7:0]                rdData,
  // interrupts, one per port
  output logic      [usc_pkg::NPORT-1:0] irq,
  // pins, one bit per port
  input  wire logic [usc_pkg::NPORT-1:0] receiveDataPinIn,
  output logic      [usc_pkg::NPORT-1:0] receiveDataPinOut,
  output logic      [usc_pkg::NPORT-1:0] receiveDataPinOe,
  input  wire logic [usc_pkg::NPORT-1:0] transmitClockPinIn,
  output logic      [usc_pkg::NPORT-1:0] transmitClockPinOut,
  output logic      [usc_pkg::NPORT-1:0] transmitClockPinOe
);
  logic [7:0] portRd [usc_pkg::NPORT];

  for (genvar i = 0; i < usc_pkg::NPORT; i++) begin : gPort
    usc_port #(.PORT_ID(1'(i))) uPort (
      .clk                 (clk),
      .resetn              (resetn),
      .addr                (addr),
      .wrData              (wrData),
      .wrEn                (wrEn),
      .rdEn                (rdEn),
      .rdData              (portRd[i]),
      .irq                 (irq[i]),
      .receiveDataPinIn    (receiveDataPinIn[i]),
      .receiveDataPinOut   (receiveDataPinOut[i]),
      .receiveDataPinOe    (receiveDataPinOe[i]),
      .transmitClockPinIn  (transmitClockPinIn[i]),
      .transmitClockPinOut (transmitClockPinOut[i]),
      .transmitClockPinOe  (transmitClockPinOe[i])
    );
  end

  // unselected port reads zero
  assign rdData = portRd[0] | portRd[1];
endmodule : usc_top

`default_nettype wire

/* test/tb_top.sv */
// bench for the dual serial port: registers, async frames, sync receive
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================
  // signals
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrEn = 1'b0;
  logic       rdEn = 1'b0;
  logic       reload = 1'b1;
  logic [7:0] rxByte = 8'h00;
  logic [7:0] rdData, rv, v;
  logic [1:0] irq, dIn, dOut, dOe, cIn, cOut, cOe;
  logic [7:0] farByte [2];
  int         bad_count = 0;
  int         check_count = 0;

  // clock at 100 MHz
  always #5 clk = ~clk;

  usc_top dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .irq(irq), .receiveDataPinIn(dIn),
    .receiveDataPinOut(dOut), .receiveDataPinOe(dOe), .transmitClockPinIn(cIn),
    .transmitClockPinOut(cOut), .transmitClockPinOe(cOe));

  // far side of each port
  for (genvar i = 0; i < 2; i++) begin : g_far
    usc_partner_model far_u (.reload(reload), .txByte(rxByte), .dataOut(dOut[i]),
      .dataOe(dOe[i]), .clkOut(cOut[i]), .clkOe(cOe[i]), .dataWire(dIn[i]),
      .clkWire(cIn[i]), .gotByte(farByte[i]));
  end

  // ==========================================
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ra(input logic p, input logic [6:0] off);
    return {p, off};
  endfunction : ra

  // expected line level of frame bit i
  function automatic logic frameBit(input logic [7:0] d, input logic nine,
                                    input logic n9, input int i);
    if (i == 0) return 1'b0;
    if (i <= 8) return d[i-1];
    if (i == 9 && nine) return n9;
    return 1'b1;
  endfunction : frameBit

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask : rc

  // poll a register until masked bits match, bounded
  task automatic waitReg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] want);
    int n;
    n = 0;
    rd(a, rv);
    while ((rv & m) !== want && n < 100) begin
      rd(a, rv);
      n++;
    end
    if ((rv & m) !== want) begin
      bad_count++;
      finish_test();
    end
  endtask : waitReg

  task automatic txFrame(input logic p, input logic [7:0] d, input logic nine,
                         input logic n9, input logic [7:0] x);
    int len;
    int n;
    logic [7:0] exp;
    len = 64 * (int'(x) + 1);
    n = 0;
    wr(ra(p, usc_pkg::OFF_RX_CTL), 8'h80);
    wr(ra(p, usc_pkg::OFF_BAUD), x);
    wr(ra(p, usc_pkg::OFF_TX_CTL), {1'b0, nine, 4'b1000, 1'b0, n9});
    wr(ra(p, usc_pkg::OFF_TX_BUF), d);
    while (cOut[p] !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cOut[p] !== 1'b0) begin
      bad_count++;
      finish_test();
    end
    // first and last cycle of every bit
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      exp = {7'h00, frameBit(d, nine, n9, i)};
      chk({7'h00, cOut[p]}, exp);
      if (i == 1) begin
        rc(ra(p, usc_pkg::OFF_TX_CTL), {1'b0, nine, 4'b1000, 1'b0, n9});
        chk({7'h00, cOe[p]}, 8'h01);
        repeat (len - 3) @(posedge clk);
      end else begin
        repeat (len - 1) @(posedge clk);
      end
      #1;
      chk({7'h00, cOut[p]}, exp);
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    rc(ra(p, usc_pkg::OFF_TX_CTL), {1'b0, nine, 4'b1000, 1'b1, n9});
  endtask : txFrame

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(21));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    reload <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      rc(ra(p[0], usc_pkg::OFF_TX_CTL), 8'h02);
      rc(ra(p[0], usc_pkg::OFF_RX_CTL), 8'h00);
      rc(ra(p[0], 7'h7F), 8'h00);
    end
    chk({4'h0, dOe, cOe}, 8'h00);
    // random control values with the port disabled
    for (int k = 0; k < 24; k++) begin
      v = 8'($urandom());
      wr(ra(v[0], usc_pkg::OFF_TX_CTL), v);
      rc(ra(v[0], usc_pkg::OFF_TX_CTL), (v & 8'hF1) | 8'h02);
      wr(ra(v[1], usc_pkg::OFF_RX_CTL), v & 8'h7F);
      rc(ra(v[1], usc_pkg::OFF_RX_CTL), v & 8'h70);
      chk({4'h0, dOe, cOe}, 8'h00);
      wr(ra(v[1], usc_pkg::OFF_RX_CTL), 8'h00);
    end
    txFrame(1'b0, 8'h01, 1'b0, 1'b0, 8'h00);
    rc(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h01);
    chk({7'h00, irq[0]}, 8'h00);
    wr(ra(1'b0, usc_pkg::OFF_IRQ_MASK), 8'h01);
    @(posedge clk);
    #1;
    chk({6'h00, irq}, 8'h01);
    wr(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, irq[0]}, 8'h00);
    txFrame(1'b1, 8'hFE, 1'b1, 1'b1, 8'h00);
    for (int k = 0; k < 3; k++) begin
      v = 8'($urandom());
      txFrame(v[0], 8'($urandom()), v[1], v[2], 8'(v[7:6] % 3));
    end
    // sync slave: single receive must not start
    wr(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'h10);
    wr(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'hFF);
    wr(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'hA0);
    repeat (50) @(posedge clk);
    chk({7'h00, cOe[0]}, 8'h00);
    rc(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'hA0);
    rc(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h00);
    // sync master: single receive of one byte
    wr(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'h80);
    wr(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'h90);
    rxByte <= 8'($urandom());
    reload <= 1'b1;
    @(posedge clk);
    reload <= 1'b0;
    wr(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'hA0);
    repeat (3) @(posedge clk);
    #1;
    chk({6'h00, cOe[0], dOe[0]}, 8'h02);
    waitReg(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h02, 8'h02);
    rc(ra(1'b0, usc_pkg::OFF_RX_BUF), rxByte);
    rc(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'h80);
    // continuous receive holds off a pending transmit
    wr(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'hB0);
    wr(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'hFF);
    wr(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'hB0);
    wr(ra(1'b0, usc_pkg::OFF_TX_BUF), 8'h3C);
    waitReg(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h02, 8'h02);
    rc(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'hB2);
    chk({7'h00, dOe[0]}, 8'h00);
    wr(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h02);
    waitReg(ra(1'b0, usc_pkg::OFF_IRQ_STAT), 8'h02, 8'h02);
    rc(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'hB0);
    wr(ra(1'b0, usc_pkg::OFF_RX_CTL), 8'h80);
    waitReg(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'h02, 8'h00);
    chk({7'h00, dOe[0]}, 8'h01);
    waitReg(ra(1'b0, usc_pkg::OFF_TX_CTL), 8'h02, 8'h02);
    chk(farByte[0], 8'h3C);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire

/* test/usc_partner.sv */
// far-side serial peripheral model: pin levels and sync slave data
`timescale 1ns/1ps
`default_nettype none

module usc_partner_model (
  // link control from the bench
  input  wire logic       reload,
  input  wire logic [7:0] txByte,
  // device pin side
  input  wire logic       dataOut,
  input  wire logic       dataOe,
  input  wire logic       clkOut,
  input  wire logic       clkOe,
  output logic            dataWire,
  output logic            clkWire,
  // byte seen on the data pin while the device drives it
  output logic      [7:0] gotByte
);
  logic [2:0] bitIdx;

  assign clkWire = clkOe ? clkOut : 1'b0;
  assign dataWire = dataOe ? dataOut : txByte[bitIdx];

  // sample device data on each rising clock, lsb first
  always @(posedge clkWire) begin
    if (dataOe) begin
      gotByte <= {dataWire, gotByte[7:1]};
    end
  end

  // next bit after each falling clock edge
  always @(negedge clkWire or posedge reload) begin
    if (reload) begin
      bitIdx <= 3'h0;
    end else begin
      bitIdx <= bitIdx + 3'h1;
    end
  end
endmodule : usc_partner_model

`default_nettype wire
